// ### hdl/fss_pkg.sv
// Constants shared by the frequency scan setup block
package fss_pkg;
    // ==========================================================
    // Register bus offsets
    localparam logic [7:0] OFF_WORD = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0C;
    localparam logic [7:0] OFF_START = 8'h10;
    localparam logic [7:0] OFF_STEP = 8'h14;
    localparam logic [7:0] OFF_COUNT = 8'h18;
    localparam logic [7:0] OFF_FREQ = 8'h1C;
    localparam logic [7:0] OFF_SCAN = 8'h20;
    // ==========================================================
    // Address codes in D15..D12 of a write word
    localparam logic [3:0] CODE_CTRL = 4'h0;
    localparam logic [3:0] CODE_COUNT = 4'h1;
    localparam logic [3:0] CODE_STEP_LO = 4'h2;
    localparam logic [3:0] CODE_STEP_HI = 4'h3;
    localparam logic [3:0] CODE_START_LO = 4'hC;
    localparam logic [3:0] CODE_START_HI = 4'hD;
    // ==========================================================
    // Control and step word bit positions
    localparam int BIT_PAIRED = 11;
    localparam int BIT_END_HOLD = 4;
    localparam int BIT_SYNC_SEL = 3;
    localparam int BIT_SYNC_OE = 2;
    localparam int BIT_STEP_NEG = 11;
    localparam logic [1:0] RSV_ONES = 2'h3;
    // ==========================================================
    // Status and interrupt bits
    localparam int ST_DONE = 0;
    localparam int ST_INCR = 1;
    localparam int ST_RSV = 2;
    // ==========================================================
    // Reset values and timing
    localparam logic [11:0] CTRL_RST = 12'h003;
    localparam logic [11:0] COUNT_RST = 12'h002;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [23:0] FREQ_RST = 24'h00_0000;
    localparam int SYNC_PULSE_CLKS = 4;
    // ==========================================================
    // Scan states
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_RUN = 2'b01,
        SCAN_DONE = 2'b10
    } fss_scan_t;
endpackage

// ### hdl/fss_scan_setup.sv
// Scan setup register bank and scan stepping of the waveform generator
`timescale 1ns/1ps
// ==========================================================
module fss_scan_setup (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Scan control from the interval logic
    input wire logic i_scan_start,
    input wire logic i_incr_tick,
    // Frequency to the phase accumulator
    output logic [23:0] o_freq,
    output logic o_midscale,
    output logic o_scan_active,
    // Sync pin
    output logic o_sync_pin,
    output logic o_sync_pin_oe,
    // Interrupt
    output logic o_irq
);
    import fss_pkg::*;

    typedef struct packed {
        logic paired;
        logic end_hold;
        logic sync_sel;
        logic sync_oe;
        logic [1:0] rsv;
        logic [23:0] start;
        logic [11:0] start_lo_pend;
        logic start_pend;
        logic [22:0] step_mag;
        logic step_neg;
        logic [11:0] step_lo_pend;
        logic step_pend;
        logic [11:0] count;
        logic [23:0] cur_freq;
        logic [11:0] done_incr;
        fss_scan_t state;
        logic active;
        logic [2:0] pulse_cnt;
        logic scan_complete;
        logic sync;
        logic midscale;
        logic [2:0] status;
        logic [2:0] mask;
        logic irq;
        logic [31:0] rdata;
    } fss_state_t;

    fss_state_t r_reg;
    fss_state_t r_next;

    logic word_wr;
    logic [3:0] code;
    logic [11:0] data12;
    logic tick_run;
    logic last_incr;
    logic [23:0] stepped;
    logic [23:0] final_calc;

    assign word_wr = i_wr && (i_addr == OFF_WORD);
    assign code = i_wdata[15:12];
    assign data12 = i_wdata[11:0];
    assign tick_run = i_incr_tick && (r_reg.state == SCAN_RUN);
    // All count steps taken; the next tick closes the final dwell
    assign last_incr = (r_reg.done_incr >= r_reg.count);
    // Signed step: magnitude plus direction bit
    assign stepped = r_reg.step_neg ?
        r_reg.cur_freq - {1'b0, r_reg.step_mag} :
        r_reg.cur_freq + {1'b0, r_reg.step_mag};
    // Expected end point, kept for checking only
    assign final_calc = r_reg.step_neg ?
        24'(r_reg.start - 24'(r_reg.count * {1'b0, r_reg.step_mag})) :
        24'(r_reg.start + 24'(r_reg.count * {1'b0, r_reg.step_mag}));

    // ==========================================================
    // Next state
    always_comb begin
        r_next = r_reg;
        r_next.rdata = 32'h0000_0000;

        // Software clear first so a same-cycle event still sets the bit
        if (i_wr && (i_addr == OFF_STATUS)) begin
            r_next.status = r_reg.status & ~i_wdata[2:0];
        end
        if (i_wr && (i_addr == OFF_MASK)) begin
            r_next.mask = i_wdata[2:0];
        end

        if (word_wr) begin
            case (code)
                CODE_CTRL: begin
                    r_next.paired = data12[BIT_PAIRED];
                    r_next.end_hold = data12[BIT_END_HOLD];
                    r_next.sync_sel = data12[BIT_SYNC_SEL];
                    r_next.sync_oe = data12[BIT_SYNC_OE];
                    r_next.rsv = data12[1:0];
                    // Reserved bits are the host's duty; flag a slip
                    if (data12[1:0] != RSV_ONES) begin
                        r_next.status[ST_RSV] = 1'b1;
                    end
                end
                CODE_COUNT: begin
                    r_next.count = data12;
                end
                CODE_START_LO: begin
                    if (r_reg.paired) begin
                        r_next.start_lo_pend = data12;
                        r_next.start_pend = 1'b1;
                    end else begin
                        r_next.start[11:0] = data12;
                    end
                end
                CODE_START_HI: begin
                    if (r_reg.paired && r_reg.start_pend) begin
                        r_next.start = {data12, r_reg.start_lo_pend};
                        r_next.start_pend = 1'b0;
                    end else begin
                        r_next.start[23:12] = data12;
                    end
                end
                CODE_STEP_LO: begin
                    if (r_reg.paired) begin
                        r_next.step_lo_pend = data12;
                        r_next.step_pend = 1'b1;
                    end else begin
                        r_next.step_mag[11:0] = data12;
                    end
                end
                CODE_STEP_HI: begin
                    r_next.step_neg = data12[BIT_STEP_NEG];
                    r_next.step_mag[22:12] = data12[10:0];
                    if (r_reg.paired && r_reg.step_pend) begin
                        r_next.step_mag[11:0] = r_reg.step_lo_pend;
                        r_next.step_pend = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        if (r_reg.pulse_cnt != 3'h0) begin
            r_next.pulse_cnt = r_reg.pulse_cnt - 3'h1;
        end

        // Scan sequencing; dwell timing lives in the interval logic
        case (r_reg.state)
            SCAN_IDLE, SCAN_DONE: begin
                if (i_scan_start) begin
                    r_next.state = SCAN_RUN;
                    r_next.cur_freq = r_reg.start;
                    r_next.done_incr = 12'h000;
                    r_next.scan_complete = 1'b0;
                    r_next.midscale = 1'b0;
                end
            end
            SCAN_RUN: begin
                if (i_scan_start) begin
                    r_next.cur_freq = r_reg.start;
                    r_next.done_incr = 12'h000;
                end else if (i_incr_tick && last_incr) begin
                    // Final frequency keeps a full dwell before the end
                    r_next.state = SCAN_DONE;
                    r_next.scan_complete = 1'b1;
                    r_next.status[ST_DONE] = 1'b1;
                    if (!r_reg.end_hold) begin
                        r_next.cur_freq = FREQ_RST;
                        r_next.midscale = 1'b1;
                    end
                end else if (i_incr_tick) begin
                    r_next.cur_freq = stepped;
                    r_next.done_incr = r_reg.done_incr + 12'h001;
                    r_next.status[ST_INCR] = 1'b1;
                    if (!r_reg.sync_sel) begin
                        r_next.pulse_cnt = 3'(SYNC_PULSE_CLKS);
                    end
                end
            end
            default: begin
                r_next.state = SCAN_IDLE;
            end
        endcase

        // Pulse mode stays quiet outside increments
        r_next.sync = r_next.sync_sel ? r_next.scan_complete :
            (r_next.pulse_cnt != 3'h0);
        r_next.irq = |(r_next.status & r_next.mask);
        r_next.active = (r_next.state == SCAN_RUN);

        if (i_rd) begin
            case (i_addr)
                OFF_STATUS: r_next.rdata = {29'h0, r_reg.status};
                OFF_MASK: r_next.rdata = {29'h0, r_reg.mask};
                OFF_CTRL: r_next.rdata = {20'h0, r_reg.paired, 6'h00,
                    r_reg.end_hold, r_reg.sync_sel, r_reg.sync_oe,
                    r_reg.rsv};
                OFF_START: r_next.rdata = {8'h00, r_reg.start};
                OFF_STEP: r_next.rdata = {8'h00, r_reg.step_neg,
                    r_reg.step_mag};
                OFF_COUNT: r_next.rdata = {20'h0, r_reg.count};
                OFF_FREQ: r_next.rdata = {8'h00, r_reg.cur_freq};
                OFF_SCAN: r_next.rdata = {16'h0, r_reg.done_incr,
                    r_reg.start_pend, r_reg.step_pend, r_reg.state};
                default: r_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            r_reg <= '0;
            r_reg.paired <= CTRL_RST[BIT_PAIRED];
            r_reg.end_hold <= CTRL_RST[BIT_END_HOLD];
            r_reg.sync_sel <= CTRL_RST[BIT_SYNC_SEL];
            r_reg.sync_oe <= CTRL_RST[BIT_SYNC_OE];
            r_reg.rsv <= CTRL_RST[1:0];
            r_reg.count <= COUNT_RST;
            r_reg.mask <= MASK_RST;
            r_reg.state <= SCAN_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_rdata = r_reg.rdata;
    assign o_freq = r_reg.cur_freq;
    assign o_midscale = r_reg.midscale;
    assign o_scan_active = r_reg.active;
    assign o_sync_pin = r_reg.sync;
    assign o_sync_pin_oe = r_reg.sync_oe;
    assign o_irq = r_reg.irq;

    // ==========================================================
    // Checks
    a_end_midscale: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        tick_run && !i_scan_start && last_incr && !r_reg.end_hold
        |=> o_midscale && (o_freq == 24'h00_0000) && !o_scan_active)
        else $error("scan end without hold did not reset output");

    a_end_final: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        tick_run && !i_scan_start && last_incr && r_reg.end_hold
        |=> !o_midscale && (o_freq == $past(final_calc)))
        else $error("held end frequency is not start plus count steps");

    a_eos_level: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        (r_reg.state == SCAN_DONE) && r_reg.sync_sel && !word_wr
        && !i_scan_start |=> o_sync_pin)
        else $error("sync level missing at scan end");

    a_eos_clear: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        i_scan_start && (r_reg.state != SCAN_RUN) && r_reg.sync_sel
        && !word_wr |=> !o_sync_pin)
        else $error("sync level not cleared at new scan");

    a_sync_pulse: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        tick_run && !i_scan_start && !r_reg.sync_sel && !word_wr
        && !last_incr |=> o_sync_pin [*4])
        else $error("increment sync pulse shorter than four clocks");

    a_sync_quiet: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        !r_reg.sync_sel && !word_wr && (r_reg.pulse_cnt == 3'h0)
        && !tick_run |=> !o_sync_pin)
        else $error("sync pulse outside an increment");

    a_sync_enable: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        word_wr && (code == CODE_CTRL)
        |=> o_sync_pin_oe == $past(i_wdata[BIT_SYNC_OE]))
        else $error("sync output enable not taken from control word");

    a_paired_hold: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        word_wr && (code == CODE_START_LO) && r_reg.paired
        |=> $stable(r_reg.start) && r_reg.start_pend)
        else $error("paired lower half changed the start register");

    a_paired_commit: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        word_wr && (code == CODE_START_HI) && r_reg.paired
        && r_reg.start_pend
        |=> r_reg.start == {$past(data12), $past(r_reg.start_lo_pend)})
        else $error("paired start commit wrong");

    a_split_write: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        word_wr && (code == CODE_START_HI) && !r_reg.paired
        |=> $stable(r_reg.start[11:0])
        && (r_reg.start[23:12] == $past(data12)))
        else $error("unpaired upper half write disturbed lower half");

    a_start_first: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        i_scan_start |=> o_freq == $past(r_reg.start))
        else $error("scan did not begin at start frequency");

    a_step_add: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        tick_run && !i_scan_start && !last_incr
        |=> o_freq == $past(stepped) && o_scan_active)
        else $error("increment did not apply the signed step");

    a_final_dwell: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        tick_run && !i_scan_start && !last_incr
        && ((r_reg.done_incr + 12'h001) == r_reg.count)
        |=> o_scan_active && (o_freq == $past(final_calc)))
        else $error("final frequency not output before the scan end");

    a_done_steady: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        (r_reg.state == SCAN_DONE) && !i_scan_start
        |=> $stable(o_freq) && !o_scan_active)
        else $error("finished scan output moved without a new start");
endmodule

// ### dv/fss_tick_model.sv
// Dwell timer model pacing scan start and increment pulses
`timescale 1ns/1ps
// ==========================================================
module fss_tick_model (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Scan request, dwell in clock periods less one, increment count
    input wire logic i_go,
    input wire logic [7:0] i_dwell,
    input wire logic [11:0] i_count,
    // Pulses to the block
    output logic o_scan_start = 1'b0,
    output logic o_incr_tick = 1'b0
);
    logic [12:0] left_reg = 13'h0000;
    logic [7:0] gap_reg = 8'h00;
    // One tick past the count closes the dwell of the final frequency
    always @(posedge i_ref_clk) begin
        o_scan_start <= 1'b0;
        o_incr_tick <= 1'b0;
        if (i_sys_rst) begin
            left_reg <= 13'h0000;
        end else if (i_go) begin
            o_scan_start <= 1'b1;
            left_reg <= {1'b0, i_count} + 13'h0001;
            gap_reg <= i_dwell;
        end else if (left_reg != 13'h0000) begin
            if (gap_reg == 8'h00) begin
                o_incr_tick <= 1'b1;
                left_reg <= left_reg - 13'h0001;
                gap_reg <= i_dwell;
            end else begin
                gap_reg <= gap_reg - 8'h01;
            end
        end
    end
endmodule

// ### dv/fss_scan_setup_test.sv
// Self-checking bench for the frequency scan setup block
`timescale 1ns/1ps
`define CHK(n, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            miscompares++; \
            $display("[ERR] %s exp %h got %h", n, e, g); \
        end \
    end
// ==========================================================
module fss_scan_setup_test;
    import fss_pkg::*;
    logic i_ref_clk;
    logic i_sys_rst;
    logic [7:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    logic i_scan_start;
    logic i_incr_tick;
    logic [23:0] o_freq;
    logic o_midscale;
    logic o_scan_active;
    logic o_sync_pin;
    logic o_sync_pin_oe;
    logic o_irq;
    logic go;
    logic [11:0] cnt;
    int comparisons = 0;
    int miscompares = 0;
    fss_scan_setup DUT (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_scan_start(i_scan_start),
        .i_incr_tick(i_incr_tick), .o_freq(o_freq),
        .o_midscale(o_midscale), .o_scan_active(o_scan_active),
        .o_sync_pin(o_sync_pin), .o_sync_pin_oe(o_sync_pin_oe),
        .o_irq(o_irq));
    // Dwell of 9 clocks leaves room for the whole sync pulse
    fss_tick_model u_model (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_go(go), .i_dwell(8'h08), .i_count(cnt),
        .o_scan_start(i_scan_start), .o_incr_tick(i_incr_tick));
    // ==========================================================
    // Register port tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic word(input logic [15:0] w);
        wr(OFF_WORD, {16'h0000, w});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string n);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(n, e, o_rdata)
    endtask
    task automatic settle();
        repeat (2) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic wait_sig(input bit tk);
        int k;
        for (k = 0; k < 40; k++) begin
            @(posedge i_ref_clk);
            if (tk ? i_incr_tick : i_scan_start) break;
        end
        `CHK("wait_sig", 1'b1, k < 40)
    endtask
    // ==========================================================
    // One scan, checking every step, the sync pin and the end state
    task automatic run_scan(input logic [11:0] n, input logic [23:0] f0,
        input logic [23:0] st, input bit neg, input bit sel, input bit hold);
        logic [23:0] e;
        int i;
        int j;
        @(posedge i_ref_clk);
        cnt <= n;
        go <= 1'b1;
        @(posedge i_ref_clk);
        go <= 1'b0;
        wait_sig(1'b0);
        #1;
        e = f0;
        `CHK("freq0", e, o_freq)
        `CHK("active", 1'b1, o_scan_active)
        @(posedge i_ref_clk);
        #1;
        `CHK("sync_new", 1'b0, o_sync_pin)
        for (i = 0; i <= n; i++) begin
            wait_sig(1'b1);
            #1;
            if (i < n) begin
                e = neg ? e - st : e + st;
                `CHK("freq", e, o_freq)
                for (j = 0; j < 5; j++) begin
                    `CHK("sync_pls", (j < 4) && !sel, o_sync_pin)
                    @(posedge i_ref_clk);
                    #1;
                end
            end else begin
                `CHK("freq_end", hold ? e : 24'h00_0000, o_freq)
                `CHK("midscale", !hold, o_midscale)
                `CHK("sync_end", sel, o_sync_pin)
                `CHK("active_end", 1'b0, o_scan_active)
            end
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    // Whole run is about 200 clocks, so this only fires on a hang
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        miscompares++;
        complete_run();
    end
    initial begin
        i_sys_rst = 1'b1;
        i_addr = 8'h00;
        i_wdata = 32'h0000_0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        go = 1'b0;
        cnt = 12'h002;
        repeat (10) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        rd(OFF_CTRL, 32'h0000_0003, "ctrl_rst");
        rd(OFF_COUNT, 32'h0000_0002, "count_rst");
        rd(OFF_MASK, 32'h0000_0000, "mask_rst");
        rd(8'h30, 32'h0000_0000, "unmapped");
        `CHK("oe_rst", 1'b0, o_sync_pin_oe)
        word(16'hC123);
        word(16'hDABC);
        rd(OFF_START, 32'h00AB_C123, "start_u");
        word(16'hC456);
        rd(OFF_START, 32'h00AB_C456, "start_lo");
        word(16'h081F);
        word(16'hC111);
        rd(OFF_START, 32'h00AB_C456, "start_pend");
        word(16'hD222);
        rd(OFF_START, 32'h0022_2111, "start_pair");
        word(16'h2005);
        rd(OFF_STEP, 32'h0000_0000, "step_pend");
        word(16'h3000);
        rd(OFF_STEP, 32'h0000_0005, "step_pair");
        word(16'h1003);
        rd(OFF_COUNT, 32'h0000_0003, "count");
        `CHK("oe_on", 1'b1, o_sync_pin_oe)
        run_scan(12'h003, 24'h22_2111, 24'h00_0005, 0, 1, 1);
        run_scan(12'h003, 24'h22_2111, 24'h00_0005, 0, 1, 1);
        rd(OFF_STATUS, 32'h0000_0003, "status");
        `CHK("irq_masked", 1'b0, o_irq)
        wr(OFF_MASK, 32'h0000_0001);
        settle();
        `CHK("irq_on", 1'b1, o_irq)
        wr(OFF_STATUS, 32'h0000_0001);
        settle();
        `CHK("irq_clr", 1'b0, o_irq)
        rd(OFF_STATUS, 32'h0000_0002, "status_w1c");
        wr(OFF_STATUS, 32'h0000_0002);
        word(16'h0804);
        rd(OFF_STATUS, 32'h0000_0004, "status_rsv");
        `CHK("irq_rsv_m", 1'b0, o_irq)
        wr(OFF_MASK, 32'h0000_0004);
        settle();
        `CHK("irq_rsv", 1'b1, o_irq)
        wr(OFF_STATUS, 32'h0000_0004);
        settle();
        `CHK("irq_rsv_c", 1'b0, o_irq)
        word(16'h0807);
        word(16'h2003);
        word(16'h3800);
        rd(OFF_STEP, 32'h0080_0003, "step_neg");
        word(16'h1002);
        run_scan(12'h002, 24'h22_2111, 24'h00_0003, 1, 0, 0);
        word(16'h0803);
        settle();
        `CHK("oe_off", 1'b0, o_sync_pin_oe)
        complete_run();
    end
endmodule
